// ---- include/tbi_consts.svh ----
`ifndef TBI_CONSTS_SVH
`define TBI_CONSTS_SVH

// register byte addresses
`define TBI_ADDR_INT  8'h00
`define TBI_ADDR_TCTL 8'h01
`define TBI_ADDR_GRP  8'h02
`define TBI_ADDR_SRC  8'h03
`define TBI_ADDR_TME  8'h04
`define TBI_ADDR_TMF  8'h05

// time_base_control
`define TBI_TCTL_RST  8'h37
`define TBI_TCTL_ON   7
`define TBI_TCTL_CK   6
`define TBI_TCTL_T1   5:4
`define TBI_TCTL_LP   3
`define TBI_TCTL_T0   2:0

// interrupt control register fields
`define TBI_INT_GIE   0
`define TBI_INT_EN    2:1
`define TBI_INT_FLG   5:4

// group and source registers: enables low nibble, flags high nibble
`define TBI_LO_NIB    3:0
`define TBI_HI_NIB    7:4
`define TBI_TMR_BITS  6:0
`define TBI_NTMR      7
`define TBI_NGRP      4
`define TBI_NVEC      6

// group membership
`define TBI_G0_SRC    1:0
`define TBI_G1_SRC    3:2
`define TBI_G2_TMR    3:0
`define TBI_G3_TMR    6:4

// synchronised inputs
`define TBI_NSYNC     3
`define TBI_SY_TSRC   0
`define TBI_SY_PIN    1
`define TBI_SY_LVD    2

// divider
`define TBI_CNT_W     15
`define TBI_T0_SHIFT  4'd8
`define TBI_T1_SHIFT  4'd12
`define TBI_DIV4_LAST 2'h3

// vector addresses, arbitrary placement
`define TBI_VA_TICK0  12'h01c
`define TBI_VA_TICK1  12'h020
`define TBI_VA_GRP0   12'h024
`define TBI_VA_GRP1   12'h028
`define TBI_VA_GRP2   12'h02c
`define TBI_VA_GRP3   12'h030

`endif

// ---- include/tbi_pkg.sv ----
`default_nettype none
package tbi_pkg;
  typedef logic [7:0]  tbi_byte_t;
  typedef logic [11:0] tbi_vaddr_t;
  typedef logic [6:0]  tbi_tmr_t;
  typedef enum logic [2:0] {
    TBI_V_TICK0,
    TBI_V_TICK1,
    TBI_V_GRP0,
    TBI_V_GRP1,
    TBI_V_GRP2,
    TBI_V_GRP3
  } tbi_vec_t;
endpackage : tbi_pkg
`default_nettype wire

// ---- include/tbi_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tbi_tick_if;
  logic       run;
  logic       tick;
  logic [2:0] t0_sel;
  logic [1:0] t1_sel;
  logic       t0_ovf;
  logic       t1_ovf;
  modport ctl (output run, tick, t0_sel, t1_sel, input t0_ovf, t1_ovf);
  modport gen (input run, tick, t0_sel, t1_sel, output t0_ovf, t1_ovf);
endinterface : tbi_tick_if
`default_nettype wire

// ---- rtl/tbi_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbi_consts.svh"
module tbi_tick_gen (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // control side
  tbi_tick_if.gen  tk
);
  import tbi_pkg::*;

  logic [`TBI_CNT_W-1:0] cnt_q;
  logic [`TBI_CNT_W-1:0] m0;
  logic [`TBI_CNT_W-1:0] m1;

  // one shared divider; both periods are tap masks on it
  always_comb
  begin
    m0 = ~({`TBI_CNT_W{1'b1}} << (4'(tk.t0_sel) + `TBI_T0_SHIFT));
    m1 = ~({`TBI_CNT_W{1'b1}} << (4'(tk.t1_sel) + `TBI_T1_SHIFT));
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || !tk.run)
      cnt_q <= '0;
    else if (tk.tick)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      tk.t0_ovf <= 1'b0;
      tk.t1_ovf <= 1'b0;
    end
    else
    begin
      tk.t0_ovf <= tk.run && tk.tick && ((cnt_q & m0) == m0);
      tk.t1_ovf <= tk.run && tk.tick && ((cnt_q & m1) == m1);
    end
  end
endmodule : tbi_tick_gen
`default_nettype wire

// ---- rtl/tbi_irq_ctrl.sv ----
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tbi_consts.svh"
module tbi_irq_ctrl (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire tbi_pkg::tbi_byte_t reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output tbi_pkg::tbi_byte_t     reg_rdata_o,
  // event sources
  input  wire logic              tick_src_clk_i,
  input  wire logic              serial_byte_done_i,
  input  wire logic              periph_edge_pin_i,
  input  wire logic              nv_cycle_done_i,
  input  wire logic              low_supply_i,
  input  wire tbi_pkg::tbi_tmr_t timer_match_i,
  // core sequencer
  input  wire logic              instr_boundary_i,
  input  wire logic              stack_full_i,
  input  wire logic              return_from_interrupt_i,
  output logic                   vector_take_o,
  output tbi_pkg::tbi_vaddr_t    vector_addr_o,
  output logic                   wake_o,
  // oscillator control
  output logic                   slow_crystal_low_power_o
);
  import tbi_pkg::*;

  // group n collects the rising/pending bits of its members
  function automatic logic [`TBI_NGRP-1:0] grp_or(
    input logic [3:0]           s,
    input logic [`TBI_NTMR-1:0] t
  );
    grp_or = {|t[`TBI_G3_TMR], |t[`TBI_G2_TMR],
              |s[`TBI_G1_SRC], |s[`TBI_G0_SRC]};
  endfunction : grp_or

  // lowest index wins
  function automatic tbi_vec_t pick(input logic [`TBI_NVEC-1:0] p);
    pick = TBI_V_TICK0;
    for (int i = `TBI_NVEC - 1; i >= 0; i--)
    begin
      if (p[i])
        pick = tbi_vec_t'(3'(i));
    end
  endfunction : pick

  function automatic tbi_vaddr_t vaddr(input tbi_vec_t v);
    unique case (v)
      TBI_V_TICK0: vaddr = `TBI_VA_TICK0;
      TBI_V_TICK1: vaddr = `TBI_VA_TICK1;
      TBI_V_GRP0:  vaddr = `TBI_VA_GRP0;
      TBI_V_GRP1:  vaddr = `TBI_VA_GRP1;
      TBI_V_GRP2:  vaddr = `TBI_VA_GRP2;
      TBI_V_GRP3:  vaddr = `TBI_VA_GRP3;
      default:     vaddr = `TBI_VA_TICK0;
    endcase
  endfunction : vaddr

  // input synchronisers
  logic [`TBI_NSYNC-1:0] sy_in;
  logic [2:0]            sy_q   [`TBI_NSYNC];
  logic                  sy_lvl_q [`TBI_NSYNC];
  logic                  sy_old_q [`TBI_NSYNC];

  assign sy_in = {low_supply_i, periph_edge_pin_i, tick_src_clk_i};

  // a level counts only once stages two and three agree, so a
  // single-cycle glitch on the pin never makes an edge
  generate
    for (genvar k = 0; k < `TBI_NSYNC; k++)
    begin : g_sync
      always_ff @(posedge mclk_i)
      begin
        if (!nrst_i)
        begin
          sy_q[k]     <= 3'h0;
          sy_lvl_q[k] <= 1'b0;
          sy_old_q[k] <= 1'b0;
        end
        else
        begin
          sy_q[k] <= {sy_q[k][1:0], sy_in[k]};
          if (sy_q[k][1] == sy_q[k][2])
            sy_lvl_q[k] <= sy_q[k][2];
          sy_old_q[k] <= sy_lvl_q[k];
        end
      end
    end
  endgenerate

  logic tsrc_rise;
  logic pin_fall;
  logic lvd_rise;

  assign tsrc_rise = sy_lvl_q[`TBI_SY_TSRC] & ~sy_old_q[`TBI_SY_TSRC];
  assign pin_fall = ~sy_lvl_q[`TBI_SY_PIN] & sy_old_q[`TBI_SY_PIN];
  assign lvd_rise = sy_lvl_q[`TBI_SY_LVD] & ~sy_old_q[`TBI_SY_LVD];

  // registers
  tbi_byte_t             tctl_q;
  logic                  gie_q;
  logic [1:0]            tick_en_q;
  logic [1:0]            tick_flag_q;
  logic [1:0]            tick_flag_d;
  logic [`TBI_NGRP-1:0]  grp_en_q;
  logic [`TBI_NGRP-1:0]  grp_flag_q;
  logic [`TBI_NGRP-1:0]  grp_flag_d;
  logic [3:0]            src_en_q;
  logic [3:0]            src_flag_q;
  logic [3:0]            src_flag_d;
  logic [`TBI_NTMR-1:0]  tmr_en_q;
  logic [`TBI_NTMR-1:0]  tmr_flag_q;
  logic [`TBI_NTMR-1:0]  tmr_flag_d;
  logic [1:0]            div_q;

  logic wr_int;
  logic wr_tctl;
  logic wr_grp;
  logic wr_src;
  logic wr_tme;
  logic wr_tmf;

  assign wr_int = reg_wr_i && (reg_addr_i == `TBI_ADDR_INT);
  assign wr_tctl = reg_wr_i && (reg_addr_i == `TBI_ADDR_TCTL);
  assign wr_grp = reg_wr_i && (reg_addr_i == `TBI_ADDR_GRP);
  assign wr_src = reg_wr_i && (reg_addr_i == `TBI_ADDR_SRC);
  assign wr_tme = reg_wr_i && (reg_addr_i == `TBI_ADDR_TME);
  assign wr_tmf = reg_wr_i && (reg_addr_i == `TBI_ADDR_TMF);

  // tick divider
  tbi_tick_if tk ();

  tbi_tick_gen u_tick_gen (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .tk     (tk.gen)
  );

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      div_q <= 2'h0;
    else
      div_q <= div_q + 1'b1;
  end

  assign tk.run    = tctl_q[`TBI_TCTL_ON];
  assign tk.tick   = tctl_q[`TBI_TCTL_CK] ? (div_q == `TBI_DIV4_LAST)
                                          : tsrc_rise;
  assign tk.t0_sel = tctl_q[`TBI_TCTL_T0];
  assign tk.t1_sel = tctl_q[`TBI_TCTL_T1];

  // vector selection
  logic [`TBI_NGRP-1:0] grp_rdy;
  logic [`TBI_NVEC-1:0] pend;
  logic                 take;
  tbi_vec_t             sel;

  // a group vectors only if an enabled member is flagged
  assign grp_rdy = grp_flag_q & grp_en_q
                 & grp_or(src_flag_q & src_en_q, tmr_flag_q & tmr_en_q);
  assign pend    = {grp_rdy, tick_flag_q & tick_en_q};
  assign sel     = pick(pend);
  assign take    = instr_boundary_i && gie_q && (|pend) && !stack_full_i;

  // flag next values: write first, then service clear, then hw set,
  // so an event in the clearing cycle is never lost
  always_comb
  begin
    tick_flag_d = tick_flag_q;
    if (wr_int)
      tick_flag_d = reg_wdata_i[`TBI_INT_FLG];
    if (take && sel == TBI_V_TICK0)
      tick_flag_d[0] = 1'b0;
    if (take && sel == TBI_V_TICK1)
      tick_flag_d[1] = 1'b0;
    tick_flag_d = tick_flag_d | {tk.t1_ovf, tk.t0_ovf};
  end

  always_comb
  begin
    src_flag_d = src_flag_q;
    if (wr_src)
      src_flag_d = reg_wdata_i[`TBI_HI_NIB];
    src_flag_d = src_flag_d
               | {lvd_rise, nv_cycle_done_i, pin_fall, serial_byte_done_i};
  end

  always_comb
  begin
    tmr_flag_d = tmr_flag_q;
    if (wr_tmf)
      tmr_flag_d = reg_wdata_i[`TBI_TMR_BITS];
    tmr_flag_d = tmr_flag_d | timer_match_i;
  end

  always_comb
  begin
    grp_flag_d = grp_flag_q;
    if (wr_grp)
      grp_flag_d = reg_wdata_i[`TBI_HI_NIB];
    for (int g = 0; g < `TBI_NGRP; g++)
    begin
      if (take && sel == tbi_vec_t'(3'(g + 2)))
        grp_flag_d[g] = 1'b0;
    end
    grp_flag_d = grp_flag_d
               | grp_or(src_flag_d & ~src_flag_q, tmr_flag_d & ~tmr_flag_q);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      tick_flag_q <= 2'h0;
      src_flag_q  <= 4'h0;
      tmr_flag_q  <= '0;
      grp_flag_q  <= '0;
    end
    else
    begin
      tick_flag_q <= tick_flag_d;
      src_flag_q  <= src_flag_d;
      tmr_flag_q  <= tmr_flag_d;
      grp_flag_q  <= grp_flag_d;
    end
  end

  // global enable: a return sets it back, and set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      gie_q <= 1'b0;
    else if (return_from_interrupt_i)
      gie_q <= 1'b1;
    else if (take)
      gie_q <= 1'b0;
    else if (wr_int)
      gie_q <= reg_wdata_i[`TBI_INT_GIE];
  end

  // enables and time base control
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      tctl_q    <= `TBI_TCTL_RST;
      tick_en_q <= 2'h0;
      grp_en_q  <= '0;
      src_en_q  <= 4'h0;
      tmr_en_q  <= '0;
    end
    else
    begin
      if (wr_tctl)
        tctl_q <= reg_wdata_i;
      if (wr_int)
        tick_en_q <= reg_wdata_i[`TBI_INT_EN];
      if (wr_grp)
        grp_en_q <= reg_wdata_i[`TBI_LO_NIB];
      if (wr_src)
        src_en_q <= reg_wdata_i[`TBI_LO_NIB];
      if (wr_tme)
        tmr_en_q <= reg_wdata_i[`TBI_TMR_BITS];
    end
  end

  // vector hand-off to the sequencer
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      vector_take_o <= 1'b0;
      vector_addr_o <= '0;
    end
    else
    begin
      vector_take_o <= take;
      if (take)
        vector_addr_o <= vaddr(sel);
    end
  end

  // wake on any flag rising, enables ignored; a flag already high
  // cannot rise again, which is how software masks wake-up
  logic [`TBI_NTMR+`TBI_NGRP+5:0] all_d;
  logic [`TBI_NTMR+`TBI_NGRP+5:0] all_q;

  assign all_d = {tick_flag_d, src_flag_d, tmr_flag_d, grp_flag_d};
  assign all_q = {tick_flag_q, src_flag_q, tmr_flag_q, grp_flag_q};

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      wake_o <= 1'b0;
    else
      wake_o <= |(all_d & ~all_q);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      slow_crystal_low_power_o <= 1'b0;
    else
      slow_crystal_low_power_o <= tctl_q[`TBI_TCTL_LP];
  end

  // read port: data valid only in the cycle after the strobe
  tbi_byte_t rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (reg_addr_i)
      `TBI_ADDR_INT:
      begin
        rd_mux[`TBI_INT_GIE] = gie_q;
        rd_mux[`TBI_INT_EN]  = tick_en_q;
        rd_mux[`TBI_INT_FLG] = tick_flag_q;
      end
      `TBI_ADDR_TCTL: rd_mux = tctl_q;
      `TBI_ADDR_GRP: rd_mux = {grp_flag_q, grp_en_q};
      `TBI_ADDR_SRC: rd_mux = {src_flag_q, src_en_q};
      `TBI_ADDR_TME: rd_mux[`TBI_TMR_BITS] = tmr_en_q;
      `TBI_ADDR_TMF: rd_mux[`TBI_TMR_BITS] = tmr_flag_q;
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
  end
endmodule : tbi_irq_ctrl
`default_nettype wire

// ---- sim/tbi_irq_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbi_consts.svh"
module tbi_irq_ctrl_chk (
  // watched ports
  input wire logic                mclk_i,
  input wire logic                nrst_i,
  input wire logic [7:0]          reg_addr_i,
  input wire tbi_pkg::tbi_byte_t  reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire tbi_pkg::tbi_byte_t  reg_rdata_o,
  input wire logic                instr_boundary_i,
  input wire logic                stack_full_i,
  input wire logic                return_from_interrupt_i,
  input wire logic                vector_take_o,
  input wire tbi_pkg::tbi_vaddr_t vector_addr_o,
  input wire logic                slow_crystal_low_power_o
);
  import tbi_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // a return or a write may re-arm the global enable, so only quiet cycles count
  sequence s_quiet;
    !return_from_interrupt_i && !reg_wr_i;
  endsequence
  sequence s_taken;
    (vector_take_o && !$past(return_from_interrupt_i) && !$past(reg_wr_i)) ##0 s_quiet [*3];
  endsequence
  sequence s_tctl_wr;
    (reg_wr_i && reg_addr_i == `TBI_ADDR_TCTL) ##1 !(reg_wr_i && reg_addr_i == `TBI_ADDR_TCTL);
  endsequence
  chk_take_single: assert property (
    vector_take_o && !$past(return_from_interrupt_i) && !$past(reg_wr_i) |=> !vector_take_o)
    else $error("vector taken twice without re-enable");
  chk_emi_gate: assert property (s_taken |=> !vector_take_o)
    else $error("vector taken while global enable cleared");
  chk_stack_block: assert property (stack_full_i |=> !vector_take_o)
    else $error("vector taken with full stack");
  chk_boundary_only: assert property (!instr_boundary_i |=> !vector_take_o)
    else $error("vector taken off instruction boundary");
  chk_vector_legal: assert property (vector_take_o |-> vector_addr_o inside
    {`TBI_VA_TICK0, `TBI_VA_TICK1, `TBI_VA_GRP0, `TBI_VA_GRP1, `TBI_VA_GRP2, `TBI_VA_GRP3})
    else $error("vector address not a vector slot");
  chk_addr_hold: assert property (!vector_take_o |-> $stable(vector_addr_o))
    else $error("vector address moved without a take");
  chk_low_power: assert property (
    s_tctl_wr |=> slow_crystal_low_power_o == $past(reg_wdata_i[3], 2))
    else $error("low power output differs from written bit");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule : tbi_irq_ctrl_chk
bind tbi_irq_ctrl tbi_irq_ctrl_chk u_chk (
  .mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .instr_boundary_i, .stack_full_i, .return_from_interrupt_i, .vector_take_o,
  .vector_addr_o, .slow_crystal_low_power_o
);
`default_nettype wire

// ---- sim/tbi_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbi_core_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // vector side
  input  wire logic vector_take_i,
  input  wire logic ret_req_i,
  input  wire logic slow_i,
  output logic      boundary_o,
  output logic      stack_full_o,
  output logic      ret_pulse_o
);
  int level_q;
  // full stack refuses vectors until a return pops a level
  assign stack_full_o = (level_q >= DEPTH);
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      level_q <= 0;
      boundary_o <= 1'b0;
      ret_pulse_o <= 1'b0;
    end
    else
    begin
      // slow core only offers every other cycle
      boundary_o <= slow_i ? ~boundary_o : 1'b1;
      ret_pulse_o <= ret_req_i && (level_q > 0);
      level_q <= level_q + int'(vector_take_i) - int'(ret_pulse_o);
    end
  end
endmodule : tbi_core_model
`default_nettype wire

// ---- sim/tbi_irq_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbi_consts.svh"
module tbi_irq_ctrl_test;
  import tbi_pkg::*;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  tbi_byte_t   reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        tick_src_clk_i = 1'b0;
  logic        serial_byte_done_i = 1'b0;
  logic        periph_edge_pin_i = 1'b1;
  logic        nv_cycle_done_i = 1'b0;
  logic        low_supply_i = 1'b0;
  tbi_tmr_t    timer_match_i = '0;
  logic        ret_req = 1'b0;
  logic        slow = 1'b0;
  logic        instr_boundary_i, stack_full_i, return_from_interrupt_i;
  logic        vector_take_o, wake_o, slow_crystal_low_power_o;
  tbi_byte_t   reg_rdata_o, d, sf;
  tbi_vaddr_t  vector_addr_o;
  logic [31:0] seed = 32'd15204;
  int          err_total = 0, comparisons = 0, n, g;
  always #20 mclk_i = ~mclk_i;
  // dedicated tick source runs at an eighth of the system clock
  always #160 tick_src_clk_i = ~tick_src_clk_i;
  tbi_irq_ctrl dut (
    .mclk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .tick_src_clk_i, .serial_byte_done_i, .periph_edge_pin_i, .nv_cycle_done_i,
    .low_supply_i, .timer_match_i, .instr_boundary_i, .stack_full_i,
    .return_from_interrupt_i, .vector_take_o, .vector_addr_o, .wake_o,
    .slow_crystal_low_power_o
  );
  tbi_core_model core (
    .mclk_i, .nrst_i, .vector_take_i(vector_take_o), .ret_req_i(ret_req), .slow_i(slow),
    .boundary_o(instr_boundary_i), .stack_full_o(stack_full_i),
    .ret_pulse_o(return_from_interrupt_i)
  );
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic int period(input tbi_byte_t t, input bit one);
    return (one ? 4096 << t[5:4] : 256 << t[2:0]) * (t[6] ? 4 : 8);
  endfunction : period
  function automatic int grp(input int k);
    return k < 2 ? 0 : (k < 4 ? 1 : (k < 8 ? 2 : 3));
  endfunction : grp
  task automatic conclude();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input tbi_byte_t v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output tbi_byte_t v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic ret();
    @(posedge mclk_i);
    ret_req <= 1'b1;
    @(posedge mclk_i);
    ret_req <= 1'b0;
  endtask : ret
  // pin and level sources need a few cycles through their synchronisers
  task automatic rearm();
    @(posedge mclk_i);
    periph_edge_pin_i <= 1'b1;
    low_supply_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask : rearm
  task automatic fire(input int k);
    @(posedge mclk_i);
    case (k)
      0: serial_byte_done_i <= 1'b1;
      1: periph_edge_pin_i <= 1'b0;
      2: nv_cycle_done_i <= 1'b1;
      3: low_supply_i <= 1'b1;
      default: timer_match_i <= tbi_tmr_t'(1 << (k - 4));
    endcase
  endtask : fire
  task automatic wait_sig(input bit take, input int lim, input bit need, output int c);
    c = 0;
    do
    begin
      @(posedge mclk_i);
      // pulses from fire end here, so a wake on that same edge is seen
      serial_byte_done_i <= 1'b0;
      nv_cycle_done_i <= 1'b0;
      timer_match_i <= '0;
      #1 c++;
    end
    while (c < lim && (take ? vector_take_o : wake_o) !== 1'b1);
    if (need && c >= lim)
    begin
      err_total++;
      $display("unexpected at %0t: waited %h of %h", $time, c, lim);
      conclude();
    end
  endtask : wait_sig
  initial
  begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(8'(a), d);
      check(d, a == 1 ? `TBI_TCTL_RST : 8'h00);
    end
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr(`TBI_ADDR_TCTL, seed[7:0] & 8'h7f);
      rd(`TBI_ADDR_TCTL, d);
      check(d, seed[7:0] & 8'h7f);
      check(slow_crystal_low_power_o, seed[3]);
    end
    // the first tick lands anywhere in one tick clock, up to 8 system clocks
    for (int m = 0; m < 6; m++)
    begin
      sf = m == 4 ? 8'h80 : (m == 5 ? 8'hc7 : 8'hc0 | 8'(m));
      wr(`TBI_ADDR_TCTL, 8'h00);
      wr(`TBI_ADDR_INT, 8'h00);
      wr(`TBI_ADDR_TCTL, sf);
      wait_sig(1'b0, 17000, 1'b1, n);
      check(n + 8 >= period(sf, m == 5) && n <= period(sf, m == 5) + 16, 1'b1);
      rd(`TBI_ADDR_INT, d);
      check(d, m == 5 ? 8'h20 : 8'h10);
    end
    wr(`TBI_ADDR_TCTL, 8'h00);
    wr(`TBI_ADDR_INT, 8'h37);
    wait_sig(1'b1, 12, 1'b1, n);
    check(vector_addr_o, `TBI_VA_TICK0);
    rd(`TBI_ADDR_INT, d);
    check(d, 8'h26);
    ret();
    wait_sig(1'b1, 12, 1'b1, n);
    check(vector_addr_o, `TBI_VA_TICK1);
    wr(`TBI_ADDR_INT, 8'h13);
    wait_sig(1'b1, 12, 1'b1, n);
    wr(`TBI_ADDR_INT, 8'h13);
    wait_sig(1'b1, 20, 1'b0, n);
    check(n, 20);
    ret();
    wait_sig(1'b1, 12, 1'b1, n);
    check(vector_addr_o, `TBI_VA_TICK0);
    ret();
    ret();
    slow <= 1'b1;
    for (int k = 0; k < 11; k++)
    begin
      g = grp(k);
      sf = k < 4 ? 8'h10 << k : 8'h01 << (k - 4);
      for (int a = 0; a < 6; a++)
        wr(8'(a), 8'h00);
      rearm();
      fire(k);
      wait_sig(1'b0, 12, 1'b1, n);
      rd(k < 4 ? `TBI_ADDR_SRC : `TBI_ADDR_TMF, d);
      check(d, sf);
      rd(`TBI_ADDR_GRP, d);
      check(d, 8'h10 << g);
      rearm();
      fire(k);
      wait_sig(1'b0, 12, 1'b0, n);
      check(n, 12);
      wr(k < 4 ? `TBI_ADDR_SRC : `TBI_ADDR_TME, k < 4 ? sf | sf >> 4 : sf);
      wr(`TBI_ADDR_GRP, 8'h11 << g);
      wr(`TBI_ADDR_INT, 8'h01);
      wait_sig(1'b1, 12, 1'b1, n);
      check(vector_addr_o, `TBI_VA_GRP0 + 12'(4 * g));
      rd(`TBI_ADDR_GRP, d);
      check(d, 8'h01 << g);
      rd(k < 4 ? `TBI_ADDR_SRC : `TBI_ADDR_TMF, d);
      check(d, k < 4 ? sf | sf >> 4 : sf);
      ret();
    end
    conclude();
  end
endmodule : tbi_irq_ctrl_test
`default_nettype wire
